// *** rtl/qb_pkg.sv ***
// Shared constants for the quasi-bidirectional port block.
package qb_pkg;

	// ****************************************
	// Port widths and reset values
	// ****************************************
	localparam int PORT_W = 8;
	// All port latches come out of reset holding ones, so every pin is released and the quasi pins float high.
	localparam logic [7:0] PORT_RST = 8'hff;
	localparam logic [7:0] DRV_ALL = 8'hff;
	localparam logic [7:0] DRV_NONE = 8'h00;

	// ****************************************
	// Bit positions of alternate functions
	// ****************************************
	localparam int P1_T2_BIT = 0;
	localparam int P1_T2EXT_BIT = 1;
	localparam int P3_RXD_BIT = 0;
	localparam int P3_TXD_BIT = 1;
	localparam int P3_IRQA_BIT = 2;
	localparam int P3_IRQB_BIT = 3;
	localparam int P3_T0_BIT = 4;
	localparam int P3_T1_BIT = 5;
	localparam int P3_WRN_BIT = 6;
	localparam int P3_RDN_BIT = 7;

	// ****************************************
	// Timing counts
	// ****************************************
	// Strong high drive after a one is written, in clock periods.
	localparam int STRONG_HI_CLKS = 2;
	localparam logic [1:0] STRONG_LOAD = 2'(STRONG_HI_CLKS - 1);
	// Oscillator clocks per machine cycle in the two timing modes.
	localparam int MC_CLKS_12 = 12;
	localparam int MC_CLKS_6 = 6;
	localparam logic [3:0] MC_LOAD_12 = 4'(MC_CLKS_12 - 1);
	localparam logic [3:0] MC_LOAD_6 = 4'(MC_CLKS_6 - 1);

endpackage : qb_pkg

// *** rtl/qb_sync.sv ***
// Three-stage pin synchroniser with a two-stage agreement filter.
`timescale 1ns/10ps
module qb_sync import qb_pkg::*; #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_q
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] agree;

	// The first stage is read by the second stage alone.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A bit changes only once stages two and three agree, which drops one-cycle glitches.
	assign agree = ~(s2_r ^ s3_r);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_q <= RST_VAL;
		end else begin
			pin_q <= (s3_r & agree) | (pin_q & ~agree);
		end
	end

endmodule : qb_sync

// *** rtl/qb_ports.sv ***
// Port logic of four 8-bit ports with multiplexed bus and alternate functions.
`timescale 1ns/10ps
module qb_ports import qb_pkg::*; (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] wdata,
	input wire logic p0_wr,
	input wire logic p1_wr,
	input wire logic p2_wr,
	input wire logic p3_wr,
	input wire logic clk6_mode,
	input wire logic ext_access,
	input wire logic ext_addr_phase,
	input wire logic ext_wdata_en,
	input wire logic [15:0] ext_addr,
	input wire logic [7:0] ext_wdata,
	input wire logic ext_wr_strobe,
	input wire logic ext_rd_strobe,
	input wire logic t2_clkout_en,
	input wire logic t2_clkout,
	input wire logic uart_txd_en,
	input wire logic uart_txd,
	input wire logic [7:0] p0_in,
	input wire logic [7:0] p1_in,
	input wire logic [7:0] p2_in,
	input wire logic [7:0] p3_in,
	output logic [7:0] p0_out,
	output logic [7:0] p0_oe,
	output logic [7:0] p1_out,
	output logic [7:0] p1_oe,
	output logic [7:0] p2_out,
	output logic [7:0] p2_oe,
	output logic [7:0] p3_out,
	output logic [7:0] p3_oe,
	output logic [7:0] p0_pins,
	output logic [7:0] p1_pins,
	output logic [7:0] p2_pins,
	output logic [7:0] p3_pins,
	output logic mc_tick,
	output logic mc_mode6
);

	// ****************************************
	// Port latches
	// ****************************************
	logic [7:0] p0_lat_r;
	logic [7:0] p1_lat_r;
	logic [7:0] p2_lat_r;
	logic [7:0] p3_lat_r;

	// Software writes land in the latches; they hold while the bus borrows a pin.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			p0_lat_r <= PORT_RST;
			p1_lat_r <= PORT_RST;
			p2_lat_r <= PORT_RST;
			p3_lat_r <= PORT_RST;
		end else begin
			if (p0_wr) p0_lat_r <= wdata;
			if (p1_wr) p1_lat_r <= wdata;
			if (p2_wr) p2_lat_r <= wdata;
			if (p3_wr) p3_lat_r <= wdata;
		end
	end

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	// The filtered pin levels feed the core, the timers, the UART and the interrupts.
	qb_sync #(.WIDTH(PORT_W), .RST_VAL(PORT_RST)) u_sync0 (
		.ref_clk(ref_clk), .rstn(rstn), .pin_in(p0_in), .pin_q(p0_pins)
	);
	qb_sync #(.WIDTH(PORT_W), .RST_VAL(PORT_RST)) u_sync1 (
		.ref_clk(ref_clk), .rstn(rstn), .pin_in(p1_in), .pin_q(p1_pins)
	);
	qb_sync #(.WIDTH(PORT_W), .RST_VAL(PORT_RST)) u_sync2 (
		.ref_clk(ref_clk), .rstn(rstn), .pin_in(p2_in), .pin_q(p2_pins)
	);
	qb_sync #(.WIDTH(PORT_W), .RST_VAL(PORT_RST)) u_sync3 (
		.ref_clk(ref_clk), .rstn(rstn), .pin_in(p3_in), .pin_q(p3_pins)
	);

	// ****************************************
	// Low byte port: open drain and bus
	// ****************************************
	// address then data
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			p0_out <= DRV_NONE;
			p0_oe <= DRV_NONE;
		end else if (ext_addr_phase) begin
			p0_out <= ext_addr[7:0];
			p0_oe <= DRV_ALL;
		end else if (ext_wdata_en) begin
			p0_out <= ext_wdata;
			p0_oe <= DRV_ALL;
		end else if (ext_access) begin
			p0_out <= DRV_NONE; // Read data phase: pins float so memory can drive them.
			p0_oe <= DRV_NONE;
		end else begin
			p0_out <= DRV_NONE;
			p0_oe <= ~p0_lat_r;
		end
	end

	// ****************************************
	// Effective values of quasi ports
	// ****************************************
	logic [7:0] p1_eff;
	logic [7:0] p3_eff;
	logic [23:0] q_eff;
	logic [23:0] q_prev_r;
	logic [23:0] q_force;
	logic [1:0] q_cnt_r [24];
	logic [23:0] q_oe_nxt;

	always_comb begin
		p1_eff = p1_lat_r;
		p3_eff = p3_lat_r;
		if (t2_clkout_en) p1_eff[P1_T2_BIT] = t2_clkout;
		if (uart_txd_en) p3_eff[P3_TXD_BIT] = uart_txd;
		if (ext_wr_strobe) p3_eff[P3_WRN_BIT] = 1'b0;
		if (ext_rd_strobe) p3_eff[P3_RDN_BIT] = 1'b0;
	end

	assign q_eff = {p3_eff, (ext_access ? ext_addr[15:8] : p2_lat_r), p1_eff};
	assign q_force = {8'h00, (ext_access ? DRV_ALL : DRV_NONE), 8'h00};

	// ****************************************
	// Quasi-bidirectional drivers
	// ****************************************
	// Enable for every quasi bit: drive lows, bus bits and the strong high window.
	// strong high window
	always_comb begin
		q_oe_nxt = '0;
		for (int i = 0; i < 24; i++) begin
			q_oe_nxt[i] = !q_eff[i] || q_force[i] ||
				(q_eff[i] && !q_prev_r[i]) || (q_cnt_r[i] != 2'h0);
		end
	end

	// A low is driven hard; a rising one gets a short strong pulse, then, except on port2 during bus access, only the
	// weak pull-up holds it, so another device can still pull the pin low.
	// strong high pulse
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			q_prev_r <= '1;
			for (int i = 0; i < 24; i++) q_cnt_r[i] <= 2'h0;
			{p3_out, p2_out, p1_out} <= '1;
			{p3_oe, p2_oe, p1_oe} <= '0;
		end else begin
			q_prev_r <= q_eff;
			for (int i = 0; i < 24; i++) begin
				if (q_eff[i] && !q_prev_r[i]) begin
					q_cnt_r[i] <= STRONG_LOAD;
				end else if (q_cnt_r[i] != 2'h0) begin
					q_cnt_r[i] <= q_cnt_r[i] - 2'h1;
				end
			end
			{p3_out, p2_out, p1_out} <= q_eff;
			{p3_oe, p2_oe, p1_oe} <= q_oe_nxt;
		end
	end

	// ****************************************
	// Machine cycle timing
	// ****************************************
	logic [3:0] mc_cnt_r;

	// The mode is taken only at a cycle boundary, so a cycle never has a mixed length.
	// 12 or 6 clocks
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mc_cnt_r <= 4'h0;
			mc_tick <= 1'b0;
			mc_mode6 <= 1'b0;
		end else if (mc_cnt_r == 4'h0) begin
			mc_cnt_r <= clk6_mode ? MC_LOAD_6 : MC_LOAD_12;
			mc_tick <= 1'b1;
			mc_mode6 <= clk6_mode;
		end else begin
			mc_cnt_r <= mc_cnt_r - 4'h1;
			mc_tick <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	od_release_a: assert property (!ext_access |=> (p0_oe & $past(p0_lat_r)) == 8'h00)
		else $error("low port drives a bit latched high");
	addr_phase_a: assert property (ext_addr_phase |=>
		p0_oe == 8'hff && p0_out == $past(ext_addr[7:0]))
		else $error("low address byte not driven");
	strong_pulse_a: assert property (!t2_clkout_en && $rose(p1_lat_r[2]) |=>
		(p1_oe[2] && p1_out[2])[*2] ##1 (!p1_oe[2] || !p1_lat_r[2]))
		else $error("strong high pulse length wrong");
	high_addr_a: assert property (ext_access |=>
		p2_oe == 8'hff && p2_out == $past(ext_addr[15:8]))
		else $error("high address byte not driven");
	t2_clkout_a: assert property (t2_clkout_en |=> p1_out[0] == $past(t2_clkout))
		else $error("timer2 clock not on pin");
	t2_control_a: assert property ($changed(p1_in[1]) ##1 $stable(p1_in[1])[*3] |=>
		p1_pins[1] == $past(p1_in[1]))
		else $error("timer2 control input not tracked");
	mc_six_a: assert property (mc_tick && mc_mode6 |=> (!mc_tick)[*5] ##1 mc_tick)
		else $error("six clock machine cycle wrong");
	mc_twelve_a: assert property (mc_tick && !mc_mode6 |=> !mc_tick ##11 mc_tick)
		else $error("twelve clock machine cycle wrong");
	wr_strobe_a: assert property (ext_wr_strobe |=> p3_oe[6] && !p3_out[6])
		else $error("write strobe not driven low");
	revert_a: assert property (!t2_clkout_en |=> p1_out[0] == $past(p1_lat_r[0]))
		else $error("pin did not fall back to latch");

	bus_read_c: cover property (ext_addr_phase ##1 (ext_access && !ext_wdata_en));
	strong_c: cover property ($rose(p1_lat_r[3]) ##3 !p1_oe[3]);
	mode6_c: cover property (mc_tick && mc_mode6);

endmodule : qb_ports

// *** testbench/qb_board.sv ***
// Board model: pin levels from the port drivers, pull-ups and outside drivers.
`timescale 1ns/10ps
module qb_board (
	input wire logic ref_clk,
	input wire logic [3:0][7:0] pout,
	input wire logic [3:0][7:0] poe,
	input wire logic [3:0][7:0] drv_en,
	input wire logic [3:0][7:0] drv_val,
	output logic [3:0][7:0] pin
);
	// Port0 has no pull-up, so a floating bit shows a changing pattern.
	logic [7:0] float_r = 8'h5a;
	always @(posedge ref_clk) begin
		float_r <= ~float_r;
	end
	// The device wins, then the board; a released quasi pin is pulled high.
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (poe[p][b])
					pin[p][b] = pout[p][b];
				else if (drv_en[p][b])
					pin[p][b] = drv_val[p][b];
				else
					pin[p][b] = (p == 0) ? float_r[b] : 1'b1;
			end
		end
	end
endmodule : qb_board

// *** testbench/testbench.sv ***
// Self-checking bench for the four-port block.
`timescale 1ns/10ps
module testbench;
	logic ref_clk, rstn, clk6_mode, t2_clkout_en, t2_clkout, uart_txd_en, uart_txd;
	logic ext_access, ext_addr_phase, ext_wdata_en, ext_wr_strobe, ext_rd_strobe;
	logic mc_tick, mc_mode6;
	logic [3:0] wr;
	logic [7:0] wdata, ext_wdata, v, nw;
	logic [15:0] ext_addr;
	wire [3:0][7:0] po, oe, pins, pin;
	logic [3:0][7:0] drv_en, drv_val, lat;
	int errors, n_compared, seed, p, g;
	qb_ports uut (.ref_clk(ref_clk), .rstn(rstn), .wdata(wdata), .p0_wr(wr[0]),
		.p1_wr(wr[1]), .p2_wr(wr[2]), .p3_wr(wr[3]), .clk6_mode(clk6_mode),
		.ext_access(ext_access), .ext_addr_phase(ext_addr_phase),
		.ext_wdata_en(ext_wdata_en), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_wr_strobe(ext_wr_strobe), .ext_rd_strobe(ext_rd_strobe),
		.t2_clkout_en(t2_clkout_en), .t2_clkout(t2_clkout), .uart_txd_en(uart_txd_en),
		.uart_txd(uart_txd), .p0_in(pin[0]), .p1_in(pin[1]), .p2_in(pin[2]),
		.p3_in(pin[3]), .p0_out(po[0]), .p0_oe(oe[0]), .p1_out(po[1]), .p1_oe(oe[1]),
		.p2_out(po[2]), .p2_oe(oe[2]), .p3_out(po[3]), .p3_oe(oe[3]),
		.p0_pins(pins[0]), .p1_pins(pins[1]), .p2_pins(pins[2]), .p3_pins(pins[3]),
		.mc_tick(mc_tick), .mc_mode6(mc_mode6));
	qb_board board (.ref_clk(ref_clk), .pout(po), .poe(oe), .drv_en(drv_en),
		.drv_val(drv_val), .pin(pin));
	// ****
	// Shared tasks
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Lets n edges land, then samples on the falling edge where outputs are settled.
	task settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle
	task wr_port(input int q, input logic [7:0] d);
		@(posedge ref_clk);
		wdata <= d;
		wr[q] <= 1'b1;
		@(posedge ref_clk);
		wr[q] <= 1'b0;
	endtask : wr_port
	// Port0 never drives a one from its latch; quasi ports add the strong pulse on rising bits.
	function automatic logic [7:0] exp_oe(int q, logic [7:0] o, logic [7:0] n, bit pls);
		if (q == 0)
			return ~n;
		return ~n | (pls ? (n & ~o) : 8'h00);
	endfunction : exp_oe
	task tick_gap(output int n);
		int k;
		k = 0;
		n = 0;
		do begin @(negedge ref_clk); k++; end while (mc_tick !== 1'b1 && k < 40);
		do begin @(negedge ref_clk); n++; end while (mc_tick !== 1'b1 && n < 40);
		if (k >= 40 || n >= 40) begin
			errors++;
			results();
		end
	endtask : tick_gap
	task results();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// ****
	// Main sequence
	// ****
	initial begin
		{rstn, clk6_mode, t2_clkout_en, t2_clkout, uart_txd_en, uart_txd} = '0;
		{ext_access, ext_addr_phase, ext_wdata_en, ext_wr_strobe, ext_rd_strobe} = '0;
		{wr, wdata, ext_wdata, ext_addr, drv_en, drv_val} = '0;
		errors = 0;
		n_compared = 0;
		seed = 32'h330c;
		lat = {4{8'hff}};
		settle(11);
		for (int q = 0; q < 4; q++) begin
			chk(oe[q], 8'h00);
			chk(po[q], (q == 0) ? 8'h00 : 8'hff);
			chk(pins[q], 8'hff);
		end
		@(posedge ref_clk);
		rstn <= 1'b1;
		// All zeros, then all ones, then random values on every port.
		for (int i = 0; i < 12; i++) begin
			p = i % 4;
			nw = (i < 4) ? 8'h00 : (i < 8) ? 8'hff : 8'($random(seed));
			wr_port(p, nw);
			settle(1);
			chk(oe[p], exp_oe(p, lat[p], nw, 1));
			chk(po[p], (p == 0) ? 8'h00 : nw);
			settle(2);
			chk(oe[p], exp_oe(p, lat[p], nw, 0));
			lat[p] = nw;
		end
		// Bus cycle with write data, then one that floats for read data.
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			{ext_addr, ext_wdata} <= 24'($random(seed));
			{ext_access, ext_addr_phase} <= 2'b11;
			@(posedge ref_clk);
			ext_addr_phase <= 1'b0;
			ext_wdata_en <= (i == 0);
			@(negedge ref_clk);
			chk(oe[0] & oe[2], 8'hff);
			chk(po[0], ext_addr[7:0]);
			chk(po[2], ext_addr[15:8]);
			@(posedge ref_clk);
			{ext_access, ext_wdata_en} <= 2'b00;
			@(negedge ref_clk);
			chk(oe[0], (i == 0) ? 8'hff : 8'h00);
			chk(po[0] & oe[0], (i == 0) ? ext_wdata : 8'h00);
			settle(4);
			chk(po[2], lat[2]);
		end
		// Strobes and alternate outputs take the bit, then give it back.
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			@(posedge ref_clk);
			{ext_wr_strobe, ext_rd_strobe, t2_clkout_en, uart_txd_en} <= 4'b1000 >> i;
			{t2_clkout, uart_txd} <= v[1:0];
			g = (i == 2) ? 8 : (i == 0) ? 30 : (i == 1) ? 31 : 25;
			nw = {7'h00, (i == 2) ? v[1] : (i == 3) ? v[0] : 1'b0};
			settle(1);
			chk({7'h00, oe[g / 8][g % 8] & ~po[g / 8][g % 8]}, {7'h00, ~nw[0]});
			@(posedge ref_clk);
			{ext_wr_strobe, ext_rd_strobe, t2_clkout_en, uart_txd_en} <= 4'h0;
			settle(4);
			chk({7'h00, oe[g / 8][g % 8] & ~po[g / 8][g % 8]}, {7'h00, ~lat[g / 8][g % 8]});
		end
		// Outside levels on released pins reach the filtered inputs.
		for (int q = 0; q < 4; q++) begin
			wr_port(q, 8'hff);
		end
		drv_val <= 32'($random(seed));
		drv_en <= {4{8'hff}};
		// The last strong pulse ends three edges after the latch, then four filter edges.
		settle(8);
		for (int q = 0; q < 4; q++) begin
			chk(pins[q], drv_val[q]);
		end
		// Every timer2 input bit flips, so the control input surely sees an edge.
		@(posedge ref_clk);
		drv_val[1] <= ~drv_val[1];
		settle(8);
		chk(pins[1], drv_val[1]);
		// Machine cycle length in both modes; the first gap may straddle a change.
		for (int m = 0; m < 2; m++) begin
			@(posedge ref_clk);
			clk6_mode <= m[0];
			tick_gap(g);
			tick_gap(g);
			chk(8'(g), m ? 8'd6 : 8'd12);
			chk(mc_mode6, m[0]);
		end
		results();
	end
endmodule : testbench
